// ==== capability_header_pkg.sv ====
// How it works
// [R1] Structure at offset 0x0c0, twenty bytes long
// [R2] Legacy mode: structure locations read as reserved
// [R3] First dword read-only, resets to 0x00710010
// [R4] Interrupt message number bits 29:25 read zero
// [R5] Next pointer bits 15:8 read 0x00
// [R6] Other fields fixed: id, version, type, slot
package capability_header_pkg;

   // ---------------------------------------------------------------
   // Placement
   // ---------------------------------------------------------------
   localparam logic [11:0] CAP_BASE_OFFSET   = 12'h0c0;
   localparam logic [11:0] CAP_SIZE_BYTES    = 12'h014;
   localparam logic [11:0] HEADER_OFFSET     = 12'h0c0;

   // ---------------------------------------------------------------
   // Field positions and values
   // ---------------------------------------------------------------
   localparam int          ID_LSB            = 0;
   localparam int          NEXT_LSB          = 8;
   localparam int          VERSION_LSB       = 16;
   localparam int          PORT_TYPE_LSB     = 20;
   localparam int          SLOT_BIT          = 24;
   localparam int          INT_MSG_LSB       = 25;
   localparam logic [7:0]  CAPABILITY_IDENTIFIER_VALUE      = 8'h10;
   localparam logic [7:0]  NEXT_PTR_VALUE    = 8'h00;
   localparam logic [3:0]  VERSION_VALUE     = 4'h1;
   localparam logic [3:0]  PORT_TYPE_VALUE   = 4'h7;
   localparam logic        SLOT_IMPL_VALUE   = 1'b0;
   localparam logic [4:0]  INT_MSG_VALUE     = 5'h00;
   localparam logic [31:0] HEADER_RESET      = 32'h0071_0010;
   localparam logic [31:0] RESERVED_READ     = 32'h0000_0000;

endpackage

// ==== cap_window_decode.sv ====
`timescale 1ns/100ps
module cap_window_decode
   import capability_header_pkg::*;
(
   // Configuration address
   input  wire logic [11:0] cfg_addr_in,
   // Decode results
   output logic             in_window_out,
   output logic             is_header_out
);
   always_comb begin
      in_window_out = (cfg_addr_in >= CAP_BASE_OFFSET) &&
                      (cfg_addr_in < CAP_BASE_OFFSET + CAP_SIZE_BYTES); // [R1]
      is_header_out = (cfg_addr_in[11:2] == HEADER_OFFSET[11:2]);        // [R3]
   end
endmodule // cap_window_decode

// ==== pcie_capability_header.sv ====
`timescale 1ns/100ps
module pcie_capability_header
   import capability_header_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        reset_n_in,
   // Mode
   input  wire logic        legacy_mode_in,
   // Configuration read
   input  wire logic        cfg_rd_in,
   input  wire logic [11:0] cfg_addr_in,
   output logic             cfg_hit_out,
   output logic [31:0]      cfg_rdata_out
);
   // ---------------------------------------------------------------
   // Structure geometry
   // ---------------------------------------------------------------
   // Twenty bytes give five dwords; only the header dword lives here
   localparam int         DWORD_COUNT = int'(CAP_SIZE_BYTES) / 4;
   localparam logic [9:0] BASE_DWORD  = CAP_BASE_OFFSET[11:2];
   localparam int         HEADER_SLOT = int'(HEADER_OFFSET[11:2] - BASE_DWORD);

   // ---------------------------------------------------------------
   // Decode and table signals
   // ---------------------------------------------------------------
   logic        in_window;
   logic        is_header;
   logic [9:0]  rel_dword;
   logic        dword_sel   [DWORD_COUNT];
   logic [31:0] struct_word [DWORD_COUNT];
   logic [31:0] header_word;
   logic [31:0] picked_word;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic        hit_r;
   logic        hit_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Bits that no field names stay zero
   function automatic logic [31:0] assemble_header();
      logic [31:0] word;
      word                     = '0;                                     // [R6]
      word[ID_LSB +: 8]        = CAPABILITY_IDENTIFIER_VALUE;                           // [R6]
      word[NEXT_LSB +: 8]      = NEXT_PTR_VALUE;                         // [R5]
      word[VERSION_LSB +: 4]   = VERSION_VALUE;                          // [R6]
      word[PORT_TYPE_LSB +: 4] = PORT_TYPE_VALUE;                        // [R6]
      word[SLOT_BIT]           = SLOT_IMPL_VALUE;                        // [R6]
      word[INT_MSG_LSB +: 5]   = INT_MSG_VALUE;                          // [R4]
      return word;
   endfunction

   // Dword position of a byte address inside the structure
   function automatic logic [9:0] dword_in_struct(input logic [11:0] byte_addr);
      return byte_addr[11:2] - BASE_DWORD;
   endfunction

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   cap_window_decode u_decode (
      .cfg_addr_in   (cfg_addr_in),
      .in_window_out (in_window),
      .is_header_out (is_header)
   );

   assign rel_dword = dword_in_struct(cfg_addr_in);                       // [R1]

   // ---------------------------------------------------------------
   // Dword table, constant since nothing here is writable
   // ---------------------------------------------------------------
   assign header_word = assemble_header();                                // [R3]

   generate
      for (genvar i = 0; i < DWORD_COUNT; i++) begin : g_dword
         if (i == HEADER_SLOT) begin : g_header
            assign struct_word[i] = header_word;                          // [R3]
            assign dword_sel[i]   = in_window && is_header;               // [R3]
         end else begin : g_other
            // Later dwords belong to other blocks and read zero here
            assign struct_word[i] = RESERVED_READ;                        // [R1]
            assign dword_sel[i]   = in_window && (rel_dword == 10'(i));   // [R1]
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Word selection
   // ---------------------------------------------------------------
   // No select outside the window, so those reads return zero
   always_comb begin
      picked_word = RESERVED_READ;
      for (int k = 0; k < DWORD_COUNT; k++) begin
         if (dword_sel[k]) begin
            picked_word = struct_word[k];
         end
      end
   end

   // ---------------------------------------------------------------
   // Hit flag: one cycle per read inside the window
   // ---------------------------------------------------------------
   // Legacy mode still claims the window, it only blanks the data
   always_comb begin
      hit_nxt = cfg_rd_in && in_window;                                   // [R1]
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         hit_r <= 1'b0;
      end else begin
         hit_r <= hit_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Read data: loaded on a read, held otherwise
   // ---------------------------------------------------------------
   always_comb begin
      rdata_nxt = rdata_r;
      if (cfg_rd_in) begin
         rdata_nxt = picked_word;                                         // [R3]
         if (legacy_mode_in) begin
            rdata_nxt = RESERVED_READ;                                    // [R2]
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         rdata_r <= HEADER_RESET;                                         // [R3]
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign cfg_rdata_out = rdata_r;
   assign cfg_hit_out   = hit_r;
endmodule // pcie_capability_header

// ==== cap_hdr_chk.sv ====
`timescale 1ns/100ps
module cap_hdr_chk(input wire logic core_clk_in, reset_n_in, legacy_mode_in, cfg_rd_in,
   input wire logic [11:0] cfg_addr_in, input wire logic cfg_hit_out,
   input wire logic [31:0] cfg_rdata_out);
   wire w = cfg_rd_in && cfg_addr_in >= 12'h0c0 && cfg_addr_in <= 12'h0d3;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   hit_window_a: assert property (##1 cfg_hit_out == $past(w)) else $error("hit");
   legacy_zero_a: assert property (cfg_rd_in && legacy_mode_in |=> !cfg_rdata_out)
      else $error("legacy");
   header_word_a: assert property (w && !legacy_mode_in && cfg_addr_in[11:2] == 10'h030
      |=> cfg_rdata_out == 32'h0071_0010) else $error("header");
   int_msg_a: assert property (cfg_hit_out |-> !cfg_rdata_out[29:25]) else $error("msg");
   next_ptr_a: assert property (cfg_hit_out |-> !cfg_rdata_out[15:8]) else $error("next");
   fixed_top_a: assert property (cfg_hit_out |-> !cfg_rdata_out[31:24]) else $error("top");
   data_hold_a: assert property (!cfg_rd_in |=> $stable(cfg_rdata_out))
      else $error("hold");
   other_word_a: assert property (w && cfg_addr_in[11:2] != 10'h030 |=> !cfg_rdata_out)
      else $error("other");
   reset_value_a: assert property (disable iff (1'b0) !reset_n_in |=>
      cfg_rdata_out == 32'h0071_0010 && !cfg_hit_out) else $error("reset");
   cover property (w ##1 w);
   cover property (cfg_rd_in && legacy_mode_in);
   cover property (cfg_rd_in && !w);
   cover property (w && !legacy_mode_in && cfg_addr_in[11:2] == 10'h030);
endmodule // cap_hdr_chk
bind pcie_capability_header cap_hdr_chk chk(.*);

// ==== cfg_reader.sv ====
`timescale 1ns/100ps
module cfg_reader(input wire logic clk_in, reset_n_in, req_in, input wire logic [11:0] addr_in,
   output logic rd_out, output logic [11:0] addr_out);
   // Idle address toggles so a stale value never looks valid
   always_ff @(posedge clk_in) begin
      rd_out <= reset_n_in && req_in;
      addr_out <= !reset_n_in ? 12'h000 : req_in ? addr_in : ~addr_out;
   end
endmodule // cfg_reader

// ==== tb_pcie_capability_header.sv ====
`timescale 1ns/100ps
module tb_pcie_capability_header;
   logic clk = 0, rst_n = 0, leg = 0, req = 0, rd, p_rd = 0, p_leg, hit;
   logic [11:0] a = 0, addr, p_a;
   logic [31:0] dat, e = 32'h0071_0010;
   int err_total = 0, checks_done = 0;
   initial forever #50 clk = ~clk;
   cfg_reader pm(.clk_in(clk), .reset_n_in(rst_n), .req_in(req), .addr_in(a), .rd_out(rd),
      .addr_out(addr));
   pcie_capability_header dut(.core_clk_in(clk), .reset_n_in(rst_n), .legacy_mode_in(leg),
      .cfg_rd_in(rd), .cfg_addr_in(addr), .cfg_hit_out(hit), .cfg_rdata_out(dat));
   function logic w(logic [11:0] x); return x >= 12'h0c0 && x <= 12'h0d3; endfunction
   // Only the first dword of the window carries the header
   function logic [31:0] exp_word(logic [11:0] x, logic legacy);
      return w(x) && !legacy && x[11:2] == 10'h030 ? 32'h0071_0010 : 32'h0;
   endfunction
   task give_verdict;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin p_rd <= rd; p_a <= addr; p_leg <= leg; end
   // Read data holds between reads, so e only moves on a read or a reset
   always @(negedge clk) if (!rst_n) e = 32'h0071_0010; else begin
      if (p_rd) e = exp_word(p_a, p_leg);
      checks_done++;
      if ({hit, dat} !== {p_rd & w(p_a), e}) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, {hit, dat}, {p_rd & w(p_a), e});
      end
   end
   initial begin
      void'($urandom(85));
      repeat (12) @(posedge clk);
      rst_n <= 1;
      for (int i = 0; i < 300; i++) begin
         @(posedge clk);
         // Mid-run reset must bring the header word back
         rst_n <= !(i >= 150 && i < 154);
         req <= i < 12 ? 1'b1 : 1'($urandom);
         a <= i < 12 ? 12'h0c0 + 12'(i % 4) : 12'h0b0 + 12'($urandom % 48);
         leg <= i < 12 ? i >= 6 : $urandom % 4 == 0;
      end
      repeat (3) @(posedge clk);
      give_verdict;
   end
endmodule // tb_pcie_capability_header
